// [hdl/adc_regs_params.svh]
// Register select codes, field positions, reset values and counts
`ifndef ADC_REGS_PARAMS_SVH
`define ADC_REGS_PARAMS_SVH
`define RS_STATUS      4'h0
`define RS_CONFIG      4'h1
`define RS_PORT        4'h2
`define RS_GAINCAL     4'h3
`define RS_RESULT      4'h4
`define RS_SYS_OFFSET  4'h5
`define RS_SYS_GAIN    4'h6
`define RS_SELF_OFFSET 4'h7
`define RS_SELF_GAIN   4'h8
`define RST_STATUS     8'h00
`define RST_CONFIG     8'h02
`define RST_PORT       8'h0f
`define RST_GAINCAL    8'h1e
`define RST_WIDE       24'h000000
`define CFG_LINE_FREQUENCY_BIT      7
`define CFG_UNIPOLAR   6
`define CFG_CLOCK_SOURCE_BIT     5
`define CFG_REFERENCE_BUFFER_BIT     4
`define CFG_SIGNAL_BUFFER_BIT     3
`define CFG_FORMAT     2
`define CFG_SINGLE_CYCLE_BIT     1
`define CMD_START      7
`define CMD_MODE       6
`define CMD_RW         0
`define DISCARD_COUNT  2'h3
`endif

// [hdl/adc_regs_pkg.sv]
// Types shared by the register bank modules
package adc_regs_pkg;
    typedef enum logic {
        WAIT_CMD  = 1'b0,
        MOVE_DATA = 1'b1
    } xfer_state_t;

    typedef struct packed {
        logic        sclkPrev;
        logic [7:0]  rxShift;
        logic [2:0]  rxCount;
        logic        byteDone;
        logic [7:0]  rxByte;
        logic [23:0] txShift;
        logic        txBit;
    } shifter_state_t;

    typedef struct packed {
        logic        valid;
        logic [23:0] word;
        logic        over;
        logic        under;
    } formatter_state_t;

    typedef struct packed {
        xfer_state_t xfer;
        logic [3:0]  sel;
        logic        rw;
        logic [1:0]  left;
        logic [15:0] acc;
        logic [7:0]  cfg;
        logic [7:0]  portCtrl;
        logic [7:0]  gainCal;
        logic [23:0] data;
        logic [23:0] sysOffset;
        logic [23:0] sysGain;
        logic [23:0] selfOffset;
        logic [23:0] selfGain;
        logic        sysOver;
        logic [2:0]  rate;
        logic        overFlag;
        logic        underFlag;
        logic        busy;
        logic        rdy;
        logic        readPending;
        logic [1:0]  discardCnt;
        logic        load;
        logic [23:0] loadWord;
        logic        dout;
        logic        doutOeN;
        logic [3:0]  gpioOut;
        logic [3:0]  gpioOeN;
    } bank_state_t;
endpackage

// [hdl/spi_shifter.sv]
// Serial byte receiver and word transmitter, sclk sampled on clk
`timescale 1ns/1ps
`default_nettype none
module spi_shifter
    import adc_regs_pkg::*;
(
    input  wire logic        clk,      // System clock
    input  wire logic        rst,      // Sync reset, active high
    input  wire logic        csN,      // Chip select, active low
    input  wire logic        sclk,     // Serial clock level
    input  wire logic        din,      // Serial data in
    input  wire logic        load,     // Load transmit word
    input  wire logic [23:0] loadWord, // Word to send, MSB first
    output logic             byteDone, // Pulse: byte received
    output logic [7:0]       rxByte,   // Last received byte
    output logic             txBit     // Current outgoing bit
);
    shifter_state_t cur;
    shifter_state_t next;

    // Sample on rising sclk, present next bit on falling sclk
    always_comb begin
        next = cur;
        next.sclkPrev = sclk;
        next.byteDone = 1'b0;
        if (csN) begin
            next.rxCount = 3'h0;
        end else if (sclk && !cur.sclkPrev) begin
            next.rxShift = {cur.rxShift[6:0], din};
            next.rxCount = cur.rxCount + 3'h1;
            if (cur.rxCount == 3'h7) begin
                next.byteDone = 1'b1;
                next.rxByte = {cur.rxShift[6:0], din};
            end
        end else if (!sclk && cur.sclkPrev) begin
            next.txBit = cur.txShift[23];
            next.txShift = {cur.txShift[22:0], 1'b0};
        end
        // Load wins: it lands while sclk is still high after the byte
        if (load) begin
            next.txShift = loadWord;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= next;
        end
    end

    assign byteDone = cur.byteDone;
    assign rxByte = cur.rxByte;
    assign txBit = cur.txBit;
endmodule
`default_nettype wire

// [hdl/result_formatter.sv]
// Clips a raw result to full scale and codes it for the output
`timescale 1ns/1ps
`default_nettype none
module result_formatter
    import adc_regs_pkg::*;
#(
    parameter int RAW_W = 26
) (
    input  wire logic                    clk,       // System clock
    input  wire logic                    rst,       // Sync reset
    input  wire logic                    rawValid,  // Pulse: raw result
    input  wire logic signed [RAW_W-1:0] raw,       // Raw signed result
    input  wire logic                    unipolar,  // Unipolar range
    input  wire logic                    offsetBin, // Bipolar offset binary
    output logic                         valid,     // Pulse: coded word
    output logic [23:0]                  word,      // Coded, clipped word
    output logic                         over,      // Clipped at maximum
    output logic                         under      // Clipped at minimum
);
    localparam logic signed [RAW_W-1:0] UNI_MAX = {{(RAW_W-24){1'b0}}, 24'hffffff};
    localparam logic signed [RAW_W-1:0] BIP_MAX = {{(RAW_W-23){1'b0}}, 23'h7fffff};
    localparam logic signed [RAW_W-1:0] BIP_MIN = {{(RAW_W-23){1'b1}}, 23'h000000};

    formatter_state_t cur;
    formatter_state_t next;
    logic signed [RAW_W-1:0] hi;
    logic signed [RAW_W-1:0] lo;
    logic signed [RAW_W-1:0] clip;

    // Range limits follow the polarity bit
    always_comb begin
        hi = unipolar ? UNI_MAX : BIP_MAX;
        lo = unipolar ? '0 : BIP_MIN;
        clip = raw;
        next = cur;
        next.valid = rawValid;
        if (rawValid) begin
            next.over = raw > hi;
            next.under = raw < lo;
            if (raw > hi) begin
                clip = hi;
            end else if (raw < lo) begin
                clip = lo;
            end
            next.word = clip[23:0];
            // Offset binary is two's complement with the sign flipped
            if (!unipolar && offsetBin) begin
                next.word[23] = ~clip[23];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= next;
        end
    end

    assign valid = cur.valid;
    assign word = cur.word;
    assign over = cur.over;
    assign under = cur.under;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_over_clip: assert property (
        rawValid && !unipolar && !offsetBin && raw > BIP_MAX
        |=> over && !under && word == 24'h7fffff)
        else $error("overrange result not clipped to maximum");

    chk_under_clip: assert property (
        rawValid && unipolar && raw < 0
        |=> under && !over && word == 24'h000000)
        else $error("underrange result not clipped to minimum");

    chk_offset_code: assert property (
        rawValid && !unipolar && offsetBin && raw == 0
        |=> word == 24'h800000 && !over && !under)
        else $error("bipolar midscale not coded as offset binary");
endmodule
`default_nettype wire

// [hdl/adc_register_bank.sv]
// Register bank of the converter, reached over the serial port
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs_params.svh"
// Contract
// - Decode select codes 0..8; 0..3 are bytes, 4..8 are 24-bit words.
// - Status at 0 and result at 4 are read-only; others read and write.
// - Flag system gain overrange when a system gain calibration overranges.
// - Rate field shows rate of held result or of last calibration.
// - Result above maximum is clipped and sets overrange; cleared in range.
// - Result below minimum is clipped and sets underrange; cleared in range.
// - Busy flag follows modulator activity: conversion or calibration.
// - Ready flag sets on a new result and stays set until cleared.
// - Result read clears ready once a later conversion has begun.
// - Line-frequency bit picks 50Hz rates when 1, 60Hz when 0.
// - Polarity bit picks unipolar range when 1, bipolar when 0.
// - Clock-source bit picks external clock when 1, internal when 0.
// - Reference-buffer bit enables buffers when 1, bypasses when 0.
// - Signal-buffer bit enables input buffer when 1, bypasses when 0.
// - Bipolar: format 0 two's complement, 1 offset binary; unipolar straight.
// - Single-cycle bit 1 converts once then sleeps; 0 converts continuously.
// - Continuous mode discards the first three results after a start.
// - Continuous mode marks end of conversion by a 0 to 1 on ready/data.
// - Port control byte sets direction and output value of each port pin.
// - Command byte with mode bit 1 is a register access with select and R/W.
// - Result read shifts 24 bits MSB first on ready/data.
module adc_register_bank
    import adc_regs_pkg::*;
#(
    parameter int RAW_W = 26
) (
    input  wire logic                    clk,         // System clock
    input  wire logic                    rst,         // Sync reset
    input  wire logic                    csN,         // Chip select, low
    input  wire logic                    sclk,        // Serial clock
    input  wire logic                    din,         // Serial data in
    output logic                         rdyDout,     // Ready / data out
    output logic                         rdyDoutOeN,  // Low drives rdyDout
    input  wire logic [3:0]              gpioIn,      // Port pin levels
    output logic [3:0]                   gpioOut,     // Port pin drive
    output logic [3:0]                   gpioOeN,     // Low drives pin
    input  wire logic                    rawValid,    // Pulse: raw result
    input  wire logic signed [RAW_W-1:0] rawResult,   // Raw result
    input  wire logic [2:0]              resultRate,  // Rate of result/cal
    input  wire logic                    convStarted, // Pulse: conv begun
    input  wire logic                    modBusy,     // Modulator active
    input  wire logic                    calDone,     // Pulse: cal finished
    input  wire logic                    sysGainOver, // Cal overranged
    output logic                         lineFreq50,  // 50Hz rate set
    output logic                         unipolar,    // Unipolar range
    output logic                         extClkSel,   // External clock
    output logic                         refBufEn,    // Reference buffers
    output logic                         sigBufEn,    // Signal buffer
    output logic                         singleCycle, // One-shot mode
    output logic [7:0]                   gainCalSel   // Gain and cal select
);
    bank_state_t cur;
    bank_state_t next;
    logic        byteDone;
    logic [7:0]  rxByte;
    logic        txBit;
    logic        fmtValid;
    logic [23:0] fmtWord;
    logic        fmtOver;
    logic        fmtUnder;
    logic        accept;
    logic        dataReadDone;
    logic        rdyInd;
    logic [23:0] wrWord;
    logic [23:0] readWord;
    logic [3:0]  portRead;
    logic [3:0]  cmdSel;
    logic        cmdWide;

    spi_shifter u_shifter (
        .clk      (clk),
        .rst      (rst),
        .csN      (csN),
        .sclk     (sclk),
        .din      (din),
        .load     (cur.load),
        .loadWord (cur.loadWord),
        .byteDone (byteDone),
        .rxByte   (rxByte),
        .txBit    (txBit)
    );

    result_formatter #(
        .RAW_W (RAW_W)
    ) u_formatter (
        .clk       (clk),
        .rst       (rst),
        .rawValid  (rawValid),
        .raw       (rawResult),
        .unipolar  (cur.cfg[`CFG_UNIPOLAR]),
        .offsetBin (cur.cfg[`CFG_FORMAT]),
        .valid     (fmtValid),
        .word      (fmtWord),
        .over      (fmtOver),
        .under     (fmtUnder)
    );

    // Inputs read back the pin, outputs read back the driven value
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_port
            assign portRead[i] = cur.portCtrl[4+i] ? cur.portCtrl[i] : gpioIn[i];
        end
    endgenerate

    // Results during the filter settling window are dropped
    assign accept = fmtValid && (cur.discardCnt == 2'h0);
    // Continuous mode shows ready high at end of conversion
    assign rdyInd = cur.cfg[`CFG_SINGLE_CYCLE_BIT] ? ~cur.rdy : cur.rdy;
    assign wrWord = {cur.acc, rxByte};
    assign cmdSel = rxByte[4:1];
    assign cmdWide = (cmdSel >= `RS_RESULT) && (cmdSel <= `RS_SELF_GAIN);

    // Read data, MSB aligned so byte registers leave first
    always_comb begin
        if (cmdSel == `RS_STATUS) begin
            readWord = {cur.sysOver, cur.rate, cur.overFlag, cur.underFlag,
                        cur.busy, cur.rdy, 16'h0000};
        end else if (cmdSel == `RS_CONFIG) begin
            readWord = {cur.cfg, 16'h0000};
        end else if (cmdSel == `RS_PORT) begin
            readWord = {cur.portCtrl[7:4], portRead, 16'h0000};
        end else if (cmdSel == `RS_GAINCAL) begin
            readWord = {cur.gainCal, 16'h0000};
        end else if (cmdSel == `RS_RESULT) begin
            readWord = cur.data;
        end else if (cmdSel == `RS_SYS_OFFSET) begin
            readWord = cur.sysOffset;
        end else if (cmdSel == `RS_SYS_GAIN) begin
            readWord = cur.sysGain;
        end else if (cmdSel == `RS_SELF_OFFSET) begin
            readWord = cur.selfOffset;
        end else if (cmdSel == `RS_SELF_GAIN) begin
            readWord = cur.selfGain;
        end else begin
            readWord = 24'h000000;
        end
    end

    // Transfer sequencing, register writes and status upkeep
    always_comb begin
        next = cur;
        next.load = 1'b0;
        dataReadDone = 1'b0;
        if (csN) begin
            next.xfer = WAIT_CMD;
            next.doutOeN = 1'b1;
            next.dout = rdyInd;
        end else begin
            next.doutOeN = 1'b0;
            case (cur.xfer)
                WAIT_CMD: begin
                    next.dout = rdyInd;
                    // Conversion commands belong to the sequencer, not here
                    if (byteDone && rxByte[`CMD_START] && rxByte[`CMD_MODE]) begin
                        next.sel = cmdSel;
                        next.rw = rxByte[`CMD_RW];
                        next.left = cmdWide ? 2'h2 : 2'h0;
                        next.acc = 16'h0000;
                        next.xfer = MOVE_DATA;
                        if (rxByte[`CMD_RW]) begin
                            next.load = 1'b1;
                            next.loadWord = readWord;
                        end
                    end
                end
                MOVE_DATA: begin
                    next.dout = cur.rw ? txBit : rdyInd;
                    if (byteDone) begin
                        next.acc = wrWord[15:0];
                        if (cur.left != 2'h0) begin
                            next.left = cur.left - 2'h1;
                        end else begin
                            next.xfer = WAIT_CMD;
                            if (cur.rw) begin
                                dataReadDone = (cur.sel == `RS_RESULT);
                            end else if (cur.sel == `RS_CONFIG) begin
                                next.cfg = {wrWord[7:1], 1'b0};
                            end else if (cur.sel == `RS_PORT) begin
                                next.portCtrl = wrWord[7:0];
                                next.gpioOut = wrWord[3:0];
                                next.gpioOeN = ~wrWord[7:4];
                            end else if (cur.sel == `RS_GAINCAL) begin
                                next.gainCal = wrWord[7:0];
                            end else if (cur.sel == `RS_SYS_OFFSET) begin
                                next.sysOffset = wrWord;
                            end else if (cur.sel == `RS_SYS_GAIN) begin
                                next.sysGain = wrWord;
                            end else if (cur.sel == `RS_SELF_OFFSET) begin
                                next.selfOffset = wrWord;
                            end else if (cur.sel == `RS_SELF_GAIN) begin
                                next.selfGain = wrWord;
                            end
                            // Status, result and unmapped codes drop the write
                        end
                    end
                end
                default: begin
                    next.xfer = WAIT_CMD;
                end
            endcase
        end

        next.busy = modBusy;
        if (calDone) begin
            next.rate = resultRate;
            next.sysOver = sysGainOver;
        end

        // Settling count restarts with each continuous start
        if (convStarted) begin
            next.discardCnt = cur.cfg[`CFG_SINGLE_CYCLE_BIT] ? 2'h0 : `DISCARD_COUNT;
        end else if (fmtValid && cur.discardCnt != 2'h0) begin
            next.discardCnt = cur.discardCnt - 2'h1;
        end

        // A read before the next start only arms the clear
        if (convStarted && cur.readPending) begin
            next.rdy = 1'b0;
            next.readPending = 1'b0;
        end
        if (dataReadDone) begin
            if (cur.busy) begin
                next.rdy = 1'b0;
                next.readPending = 1'b0;
            end else begin
                next.readPending = 1'b1;
            end
        end
        // A new result comes last so it wins over any clear
        if (accept) begin
            next.data = fmtWord;
            next.overFlag = fmtOver;
            next.underFlag = fmtUnder;
            next.rate = resultRate;
            next.rdy = 1'b1;
            next.readPending = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cur <= '0;
            cur.cfg <= `RST_CONFIG;
            cur.portCtrl <= `RST_PORT;
            cur.gainCal <= `RST_GAINCAL;
            cur.gpioOut <= 4'hf;
            cur.gpioOeN <= 4'hf;
            cur.doutOeN <= 1'b1;
            cur.dout <= 1'b1;
        end else begin
            cur <= next;
        end
    end

    // Configuration straight from the held register bits
    assign lineFreq50 = cur.cfg[`CFG_LINE_FREQUENCY_BIT];
    assign unipolar = cur.cfg[`CFG_UNIPOLAR];
    assign extClkSel = cur.cfg[`CFG_CLOCK_SOURCE_BIT];
    assign refBufEn = cur.cfg[`CFG_REFERENCE_BUFFER_BIT];
    assign sigBufEn = cur.cfg[`CFG_SIGNAL_BUFFER_BIT];
    assign singleCycle = cur.cfg[`CFG_SINGLE_CYCLE_BIT];
    assign gainCalSel = cur.gainCal;
    assign gpioOut = cur.gpioOut;
    assign gpioOeN = cur.gpioOeN;
    assign rdyDout = cur.dout;
    assign rdyDoutOeN = cur.doutOeN;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Result read finishing while busy, then ready low next cycle
    sequence s_read_busy;
        dataReadDone && cur.busy && !accept;
    endsequence
    sequence s_ready_low;
        !cur.rdy && !cur.readPending;
    endsequence

    chk_rdy_read_clear: assert property (s_read_busy |=> s_ready_low)
        else $error("ready not cleared after result read during conversion");

    chk_rdy_armed: assert property (
        cur.readPending && convStarted && !accept
        |=> !cur.rdy)
        else $error("armed ready not cleared at next start");

    chk_rdy_set: assert property (accept |=> cur.rdy && cur.data == $past(fmtWord))
        else $error("accepted result did not set ready");

    chk_result_ro: assert property (
        byteDone && cur.xfer == MOVE_DATA && !cur.rw && cur.left == 2'h0
        && cur.sel == `RS_RESULT && !accept |=> $stable(cur.data))
        else $error("write changed the result register");

    chk_unused_zero: assert property (cur.cfg[0] == 1'b0)
        else $error("unused config bit reads nonzero");

    chk_busy_follow: assert property (modBusy |=> cur.busy ##1 (cur.busy == $past(modBusy)))
        else $error("busy flag does not follow the modulator");

    chk_gpio_dir: assert property (gpioOeN == ~cur.portCtrl[7:4])
        else $error("pin drive enable disagrees with direction bits");

    chk_discard_arm: assert property (
        convStarted && !cur.cfg[`CFG_SINGLE_CYCLE_BIT] |=> cur.discardCnt == 2'h3)
        else $error("settling count not armed on continuous start");

    chk_flag_track: assert property (accept |=> cur.overFlag == $past(fmtOver)
        && cur.underFlag == $past(fmtUnder))
        else $error("range flags do not follow the accepted result");

    chk_rate_hold: assert property (accept |=> cur.rate == $past(resultRate))
        else $error("rate field not taken with the result");

    chk_dout_float: assert property (csN |=> rdyDoutOeN)
        else $error("ready/data driven while deselected");

    chk_cal_status: assert property (
        calDone && !accept
        |=> cur.sysOver == $past(sysGainOver) && cur.rate == $past(resultRate))
        else $error("calibration did not update overrange flag and rate");

    // Continuous result taken, then the idle pin must rise
    sequence s_result_taken;
        accept && !cur.cfg[`CFG_SINGLE_CYCLE_BIT];
    endsequence

    chk_ready_rise: assert property (
        s_result_taken ##1 (csN && !cur.cfg[`CFG_SINGLE_CYCLE_BIT]) |=> rdyDout)
        else $error("ready/data did not rise at end of conversion");

    chk_wide_select: assert property (
        byteDone && !csN && cur.xfer == WAIT_CMD && rxByte[7:6] == 2'h3
        && rxByte[4:1] == `RS_SELF_GAIN |=> cur.left == 2'h2 && cur.xfer == MOVE_DATA)
        else $error("top select code not taken as a 24-bit register");
endmodule
`default_nettype wire

// [test/spi_host.sv]
// Serial host model that runs register accesses on the converter port
`timescale 1ns/1ps
`default_nettype none
module spi_host (
    input  wire logic clk,  // Bench clock
    input  wire logic dout, // Ready/data from the device
    output logic      csN,  // Chip select, active low
    output logic      sclk, // Serial clock
    output logic      din   // Serial data to the device
);
    initial begin
        csN = 1'h1;
        sclk = 1'h0;
        din = 1'h0;
    end

    // One byte MSB first; 6-clock phases stay above the 4-clock minimum
    task automatic xbyte(input logic [7:0] o, output logic [7:0] i);
        for (int b = 7; b >= 0; b--) begin
            @(negedge clk);
            din = o[b];
            repeat (6) @(negedge clk);
            i[b] = dout;
            sclk = 1'h1;
            repeat (6) @(negedge clk);
            sclk = 1'h0;
        end
    endtask

    // Command byte, then one or three data bytes with select held low
    task automatic access(input logic [3:0] sel, input logic rw, input logic [23:0] w,
                          output logic [23:0] r);
        logic [7:0] b;
        int         n;
        n = (sel inside {[4'h4:4'h8]}) ? 3 : 1;
        @(negedge clk);
        csN = 1'h0;
        xbyte({2'h3, 1'h0, sel, rw}, b);
        r = 24'h000000;
        for (int k = n - 1; k >= 0; k--) begin
            xbyte(w[8*k +: 8], b);
            r[8*k +: 8] = b;
        end
        repeat (4) @(negedge clk);
        csN = 1'h1;
        repeat (4) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// [test/testbench.sv]
// Self-checking bench for the converter register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic               clk, rst, csN, sclk, din, rdyDout, rdyDoutOeN;
    logic               rawValid, convStarted, modBusy, calDone, sysGainOver;
    logic signed [25:0] rawResult;
    logic [2:0]         resultRate;
    logic [3:0]         gpioIn, gpioOut, gpioOeN;
    wire logic [5:0]    cfgBits;
    logic [7:0]         gainCalSel;
    logic [23:0]        rd;
    logic [23:0]        rstVals [9] = '{24'h00, 24'h02, 24'h0f, 24'h1e, 0, 0, 0, 0, 0};
    int                 numErrors, nTests;

    adc_register_bank dut (.clk(clk), .rst(rst), .csN(csN), .sclk(sclk), .din(din),
        .rdyDout(rdyDout), .rdyDoutOeN(rdyDoutOeN), .gpioIn(gpioIn), .gpioOut(gpioOut),
        .gpioOeN(gpioOeN), .rawValid(rawValid), .rawResult(rawResult),
        .resultRate(resultRate), .convStarted(convStarted), .modBusy(modBusy),
        .calDone(calDone), .sysGainOver(sysGainOver), .lineFreq50(cfgBits[5]),
        .unipolar(cfgBits[4]), .extClkSel(cfgBits[3]), .refBufEn(cfgBits[2]),
        .sigBufEn(cfgBits[1]), .singleCycle(cfgBits[0]), .gainCalSel(gainCalSel));
    spi_host host (.clk(clk), .dout(rdyDout), .csN(csN), .sclk(sclk), .din(din));

    // 250 MHz clock
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        nTests++;
        if (got !== exp) begin
            numErrors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [3:0] sel, input logic [23:0] exp);
        host.access(sel, 1'h1, 24'h000000, rd);
        check(rd, exp);
    endtask
    task automatic wr(input logic [3:0] sel, input logic [23:0] w);
        host.access(sel, 1'h0, w, rd);
    endtask
    // Core events as one-clock pulses: {rawValid, convStarted, calDone}
    task automatic core(input logic [25:0] r, input logic [2:0] rt, input logic [2:0] p);
        @(negedge clk);
        rawResult = r;
        resultRate = rt;
        {rawValid, convStarted, calDone} = p;
        @(negedge clk);
        {rawValid, convStarted, calDone} = 3'h0;
        repeat (4) @(negedge clk);
    endtask
    task automatic testDone;
        $display("comparisons %0d mismatches %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Main sequence of register accesses
    initial begin
        {rst, rawValid, convStarted, modBusy, calDone, sysGainOver} = 6'h20;
        rawResult = 26'h0;
        resultRate = 3'h0;
        gpioIn = 4'hf;
        repeat (2) @(negedge clk);
        rst = 1'h0;
        foreach (rstVals[i]) rc(i[3:0], rstVals[i]);
        check({rdyDoutOeN, rdyDout}, 24'h000003);
        check(gainCalSel, 24'h00001e);
        $display("test reset values done");
        wr(4'h1, 24'hff);
        rc(4'h1, 24'hfe);
        check(cfgBits, 24'h3f);
        wr(4'h1, 24'h00);
        check(cfgBits, 24'h00);
        wr(4'h1, 24'h02);
        wr(4'h0, 24'hff);
        rc(4'h0, 24'h00);
        wr(4'h4, 24'h123456);
        rc(4'h4, 24'h000000);
        for (int i = 5; i < 9; i++) begin
            wr(i[3:0], 24'ha5c300 + i);
            rc(i[3:0], 24'ha5c300 + i);
        end
        rc(4'h9, 24'h00);
        gpioIn = 4'h0;
        wr(4'h2, 24'ha5);
        rc(4'h2, 24'ha0);
        check({gpioOeN, gpioOut}, 24'h55);
        $display("test register access done");
        core(26'h1000000, 3'h5, 3'h4);
        rc(4'h0, 24'h59);
        rc(4'h4, 24'h7fffff);
        core(26'h3700000, 3'h5, 3'h4);
        rc(4'h0, 24'h55);
        rc(4'h4, 24'h800000);
        core(26'h0, 3'h5, 3'h2);
        rc(4'h0, 24'h54);
        modBusy = 1'h1;
        rc(4'h0, 24'h56);
        modBusy = 1'h0;
        sysGainOver = 1'h1;
        core(26'h0, 3'h3, 3'h1);
        rc(4'h0, 24'hb4);
        $display("test status flags done");
        // Continuous mode: three settling results dropped, then ready rises
        wr(4'h1, 24'h00);
        core(26'h0, 3'h1, 3'h2);
        repeat (3) core(26'h5, 3'h1, 3'h4);
        rc(4'h4, 24'h800000);
        check(rdyDout, 24'h000000);
        core(26'h5, 3'h1, 3'h4);
        check(rdyDout, 24'h000001);
        modBusy = 1'h1;
        rc(4'h4, 24'h000005);
        rc(4'h0, 24'h92);
        modBusy = 1'h0;
        $display("test continuous mode done");
        testDone();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #200000;
        numErrors++;
        testDone();
    end
endmodule
`default_nettype wire
